// file: logic/pdm_pkg.sv
// Package: register layout, modes and timing for the power-down mode control
package pdm_pkg;
  // ****************************************
  // Register addresses and reset values
  // ****************************************
  localparam logic [0:0] ADDR_CTRL_A = 1'h0;
  localparam logic [0:0] ADDR_CTRL_B = 1'h1;
  localparam logic [7:0] RESET_CTRL_A = 8'h07;
  localparam logic [7:0] RESET_CTRL_B = 8'hE0;
  localparam logic [7:0] FIXED_ONES_A = 8'h04;
  localparam logic [7:0] FIXED_ONES_B = 8'hE0;
  localparam logic [7:0] WMASK_A = 8'hFB;
  localparam logic [7:0] WMASK_B = 8'h1F;
  localparam logic [7:0] WMASK_B_SUB = 8'h1C;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_STANDBY = 7;
  localparam int BIT_SETTLE_HI = 6;
  localparam int BIT_SETTLE_LO = 4;
  localparam int BIT_LOW_SPEED = 3;
  localparam int BIT_MED_HI = 1;
  localparam int BIT_MED_LO = 0;
  localparam int BIT_NOISE = 4;
  localparam int BIT_DIRECT = 3;
  localparam int BIT_MEDIUM = 2;
  localparam int BIT_SUB_HI = 1;
  localparam int BIT_SUB_LO = 0;
  // ****************************************
  // Timing
  // ****************************************
  localparam int SETTLE_BASE = 8192;
  localparam int SETTLE_MAX_SHIFT = 4;
  localparam int DIV_W = 8;
  localparam int SETTLE_W = 18;
  localparam logic [DIV_W-1:0] MED_DIV_BASE = 8'h10;
  localparam logic [DIV_W-1:0] NOISE_SLOW = 8'h10;
  localparam logic [DIV_W-1:0] NOISE_FAST = 8'h04;
  localparam logic [DIV_W-1:0] SUB_DIV_BASE = 8'h08;
  // ****************************************
  // Operating modes
  // ****************************************
  typedef enum logic [3:0] {
    MODE_ACT_HIGH = 4'h0,
    MODE_ACT_MED = 4'h1,
    MODE_SLEEP_HIGH = 4'h3,
    MODE_SLEEP_MED = 4'h2,
    MODE_SUBACT = 4'h6,
    MODE_SUBSLEEP = 4'h7,
    MODE_WATCH = 4'h5,
    MODE_STANDBY = 4'h4,
    MODE_SETTLE = 4'hC
  } pdm_mode_t;
endpackage

// file: logic/pdm_power_mode.sv
// Power-down mode control: control registers, mode machine and dividers
// What this block does
// - Control register A resets to 07 hex.
// - Standby select clear: active goes to sleep, subactive to subsleep.
// - Standby select set: active to standby or watch, subactive to watch.
// - Settle code picks 8192, 16384, 32768, 65536 or 131072 states.
// - Low-speed select picks system clock or subclock after watch.
// - Bit 2 of register A reads 1 and ignores writes.
// - Medium divider picks oscillator over 16, 32, 64 or 128.
// - Control register B resets to E0 hex.
// - Bits 7 to 5 of register B read 1, ignore writes.
// - Noise select pulses noise_sample_en at oscillator over 16 or 4.
// - Direct transfer clear: normal sleep, standby or watch entries.
// - Direct from high-speed to medium-speed or subactive.
// - Direct from medium-speed to high-speed or subactive.
// - Direct from subactive to high-speed or medium-speed.
// - Wake from standby, watch or sleep to high speed, medium speed or subactive.
// - Sleep from active goes high or medium sleep per medium bit.
// - Subactive clock is watch clock over 8, 4 or 2.
// - Writes to subactive divider are ignored in subactive mode.
// - Standby with timebase clear stops the system clock.
// - Standby wake restarts clock, waits settle time, then services.
`timescale 1ns/100ps
`default_nettype none
module pdm_power_mode
  import pdm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Register port
  input wire logic addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // CPU and system events
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic timer_timebase_select,
  input wire logic watch_clk,
  // Mode and clock outputs
  output pdm_mode_t mode,
  output logic osc_run,
  output logic clock_hold,
  output logic service_start,
  output logic cpu_clk_en,
  output logic cpu_on_sub,
  output logic noise_sample_en
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] ctrl_a, next_ctrl_a, ctrl_b, next_ctrl_b;
  logic [7:0] next_rdata;
  logic standby_select, low_speed_select, medium_speed_select;
  logic direct_transfer_select, noise_sample_rate_select;
  logic [2:0] settle_code;
  logic [1:0] medium_div_sel, sub_div_sel;
  assign standby_select = ctrl_a[BIT_STANDBY];
  assign settle_code = ctrl_a[BIT_SETTLE_HI:BIT_SETTLE_LO];
  assign low_speed_select = ctrl_a[BIT_LOW_SPEED];
  assign medium_div_sel = ctrl_a[BIT_MED_HI:BIT_MED_LO];
  assign noise_sample_rate_select = ctrl_b[BIT_NOISE];
  assign direct_transfer_select = ctrl_b[BIT_DIRECT];
  assign medium_speed_select = ctrl_b[BIT_MEDIUM];
  assign sub_div_sel = ctrl_b[BIT_SUB_HI:BIT_SUB_LO];

  always_comb begin
    next_ctrl_a = ctrl_a;
    next_ctrl_b = ctrl_b;
    next_rdata = rdata;
    if (wr && addr == ADDR_CTRL_A) begin
      next_ctrl_a = (wdata & WMASK_A) | FIXED_ONES_A;
    end
    if (wr && addr == ADDR_CTRL_B) begin
      // fixed bits; sub divider locked in subactive
      if (mode == MODE_SUBACT) begin
        next_ctrl_b = (wdata & WMASK_B_SUB) | (ctrl_b & ~WMASK_B_SUB);
      end else begin
        next_ctrl_b = (wdata & WMASK_B) | FIXED_ONES_B;
      end
    end
    if (rd) begin
      next_rdata = (addr == ADDR_CTRL_A) ? ctrl_a : ctrl_b;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_a <= RESET_CTRL_A;
      ctrl_b <= RESET_CTRL_B;
      rdata <= 8'h00;
    end else begin
      ctrl_a <= next_ctrl_a;
      ctrl_b <= next_ctrl_b;
      rdata <= next_rdata;
    end
  end

  // ****************************************
  // Watch clock synchroniser
  // ****************************************
  // Pin input: three stages, edge counted when second and third agree
  logic [2:0] wsync, next_wsync;
  logic watch_level, next_watch_level, watch_rise;
  always_comb begin
    next_wsync = {wsync[1:0], watch_clk};
    next_watch_level = watch_level;
    if (wsync[1] == wsync[2]) begin
      next_watch_level = wsync[2];
    end
  end
  assign watch_rise = next_watch_level && !watch_level;
  always_ff @(posedge clk) begin
    if (srst) begin
      wsync <= 3'h0;
      watch_level <= 1'b0;
    end else begin
      wsync <= next_wsync;
      watch_level <= next_watch_level;
    end
  end

  // ****************************************
  // Clock dividers
  // ****************************************
  logic [DIV_W-1:0] med_cnt, next_med_cnt, med_period, next_med_period;
  logic [DIV_W-1:0] sub_cnt, next_sub_cnt, sub_period, next_sub_period;
  logic [DIV_W-1:0] nz_cnt, next_nz_cnt, nz_period, next_nz_period;
  logic med_tick, sub_tick;
  // oscillator over 16 shifted by the code
  // new period only taken at wrap
  assign med_tick = (med_cnt == med_period - 8'h01);
  // watch clock over 8, 4 or 2
  assign sub_tick = watch_rise && (sub_cnt == sub_period - 8'h01);
  assign noise_sample_en = (nz_cnt == nz_period - 8'h01);
  always_comb begin
    next_med_cnt = med_tick ? 8'h00 : med_cnt + 8'h01;
    next_med_period = med_tick ? (MED_DIV_BASE << medium_div_sel)
                               : med_period;
    next_sub_cnt = sub_cnt;
    next_sub_period = sub_period;
    if (watch_rise) begin
      next_sub_cnt = sub_tick ? 8'h00 : sub_cnt + 8'h01;
    end
    if (sub_tick) begin
      next_sub_period = sub_div_sel[1] ? (SUB_DIV_BASE >> 2)
                      : (SUB_DIV_BASE >> sub_div_sel[0]);
    end
    next_nz_cnt = noise_sample_en ? 8'h00 : nz_cnt + 8'h01;
    next_nz_period = nz_period;
    if (noise_sample_en) begin
      next_nz_period = noise_sample_rate_select ? NOISE_FAST : NOISE_SLOW;
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      med_cnt <= 8'h00;
      med_period <= MED_DIV_BASE << 3;
      sub_cnt <= 8'h00;
      sub_period <= SUB_DIV_BASE;
      nz_cnt <= 8'h00;
      nz_period <= NOISE_SLOW;
    end else begin
      med_cnt <= next_med_cnt;
      med_period <= next_med_period;
      sub_cnt <= next_sub_cnt;
      sub_period <= next_sub_period;
      nz_cnt <= next_nz_cnt;
      nz_period <= next_nz_period;
    end
  end

  // ****************************************
  // Mode machine
  // ****************************************
  pdm_mode_t next_mode;
  logic [SETTLE_W-1:0] settle_cnt, next_settle_cnt;
  logic settle_to_sub, next_settle_to_sub;
  logic active_now, next_service;
  assign active_now = (mode == MODE_ACT_HIGH) || (mode == MODE_ACT_MED);

  always_comb begin
    next_mode = mode;
    next_settle_cnt = settle_cnt;
    next_settle_to_sub = settle_to_sub;
    next_service = 1'b0;
    case (mode)
      MODE_ACT_HIGH, MODE_ACT_MED, MODE_SUBACT: begin
        if (sleep_exec) begin
          if (direct_transfer_select && mode == MODE_ACT_HIGH &&
              !standby_select && medium_speed_select &&
              !low_speed_select) begin
            next_mode = MODE_ACT_MED;
          end else if (direct_transfer_select && mode == MODE_ACT_MED &&
              !standby_select && !medium_speed_select &&
              !low_speed_select) begin
            next_mode = MODE_ACT_HIGH;
          end else if (direct_transfer_select && active_now &&
              standby_select && timer_timebase_select &&
              low_speed_select) begin
            next_mode = MODE_SUBACT;
          end else if (direct_transfer_select && mode == MODE_SUBACT &&
              standby_select && timer_timebase_select &&
              !low_speed_select) begin
            next_mode = medium_speed_select ? MODE_ACT_MED : MODE_ACT_HIGH;
          end else if (!standby_select) begin
            if (mode == MODE_SUBACT) begin
              next_mode = MODE_SUBSLEEP;
            end else begin
              next_mode = medium_speed_select ? MODE_SLEEP_MED
                                              : MODE_SLEEP_HIGH;
            end
          end else if (mode == MODE_SUBACT || timer_timebase_select ||
              low_speed_select) begin
            next_mode = MODE_WATCH;
          end else begin
            next_mode = MODE_STANDBY;
          end
        end
      end
      MODE_SLEEP_HIGH, MODE_SLEEP_MED, MODE_SUBSLEEP: begin
        // sleep resumes in its own speed
        if (wake_irq) begin
          next_mode = (mode == MODE_SUBSLEEP) ? MODE_SUBACT :
                      (mode == MODE_SLEEP_MED) ? MODE_ACT_MED : MODE_ACT_HIGH;
          next_service = 1'b1;
        end
      end
      MODE_STANDBY, MODE_WATCH: begin
        if (wake_irq) begin
          next_mode = MODE_SETTLE;
          next_settle_cnt = SETTLE_W'(SETTLE_BASE) << (settle_code[2] ?
              SETTLE_MAX_SHIFT : int'(settle_code[1:0]));
          next_settle_to_sub = (mode == MODE_WATCH) && low_speed_select;
        end
      end
      MODE_SETTLE: begin
        next_settle_cnt = settle_cnt - SETTLE_W'(1);
        if (settle_cnt == SETTLE_W'(1)) begin
          next_mode = settle_to_sub ? MODE_SUBACT :
                      medium_speed_select ? MODE_ACT_MED : MODE_ACT_HIGH;
          next_service = 1'b1;
        end
      end
      default: next_mode = MODE_ACT_HIGH;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode <= MODE_ACT_HIGH;
      settle_cnt <= '0;
      settle_to_sub <= 1'b0;
      service_start <= 1'b0;
    end else begin
      mode <= next_mode;
      settle_cnt <= next_settle_cnt;
      settle_to_sub <= next_settle_to_sub;
      service_start <= next_service;
    end
  end

  // ****************************************
  // Clock control outputs
  // ****************************************
  // oscillator halted in standby, watch and sub modes
  assign osc_run = !(mode == MODE_STANDBY || mode == MODE_WATCH ||
                     mode == MODE_SUBACT || mode == MODE_SUBSLEEP);
  // chip clock withheld during the settle wait
  assign clock_hold = (mode == MODE_SETTLE);
  assign cpu_on_sub = (mode == MODE_SUBACT);
  // medium and subactive enables are whole-period ticks of the selected divider
  assign cpu_clk_en = (mode == MODE_ACT_HIGH) ? 1'b1 :
                      (mode == MODE_ACT_MED) ? med_tick :
                      (mode == MODE_SUBACT) ? sub_tick : 1'b0;

  // ****************************************
  // Check helpers
  // ****************************************
  // Rates counted apart from the dividers, so a bad reload shows up
  logic [DIV_W-1:0] gap_med, next_gap_med, gap_sub, next_gap_sub;
  logic [DIV_W-1:0] want_med, want_sub;
  logic med_seen, next_med_seen, sub_seen, next_sub_seen;
  always_comb begin
    next_gap_med = 8'h00;
    next_med_seen = 1'b0;
    next_gap_sub = 8'h00;
    next_sub_seen = 1'b0;
    if (mode == MODE_ACT_MED) begin
      next_gap_med = cpu_clk_en ? 8'h00 : gap_med + 8'h01;
      next_med_seen = med_seen || cpu_clk_en;
    end
    if (mode == MODE_SUBACT) begin
      next_gap_sub = gap_sub;
      if (cpu_clk_en) begin
        next_gap_sub = 8'h00;
      end else if (watch_rise) begin
        next_gap_sub = gap_sub + 8'h01;
      end
      next_sub_seen = sub_seen || cpu_clk_en;
    end
    case (medium_div_sel)
      2'h0: want_med = MED_DIV_BASE;
      2'h1: want_med = MED_DIV_BASE << 2'h1;
      2'h2: want_med = MED_DIV_BASE << 2'h2;
      default: want_med = MED_DIV_BASE << 2'h3;
    endcase
    case (sub_div_sel)
      2'h0: want_sub = SUB_DIV_BASE;
      2'h1: want_sub = SUB_DIV_BASE >> 2'h1;
      default: want_sub = SUB_DIV_BASE >> 2'h2;
    endcase
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_med <= 8'h00;
      med_seen <= 1'b0;
      gap_sub <= 8'h00;
      sub_seen <= 1'b0;
    end else begin
      gap_med <= next_gap_med;
      med_seen <= next_med_seen;
      gap_sub <= next_gap_sub;
      sub_seen <= next_sub_seen;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  chk_reset_a: assert property (@(posedge clk) srst |=> ctrl_a == 8'h07)
    else $error("register A reset value wrong");
  chk_reset_b: assert property (@(posedge clk) srst |=> ctrl_b == 8'hE0)
    else $error("register B reset value wrong");
  chk_fixed_a: assert property (@(posedge clk) disable iff (srst)
    ctrl_a[2]) else $error("register A bit 2 not one");
  chk_fixed_b: assert property (@(posedge clk) disable iff (srst)
    ctrl_b[7:5] == 3'h7) else $error("register B top bits not one");
  chk_sub_lock: assert property (@(posedge clk) disable iff (srst)
    mode == MODE_SUBACT && !sleep_exec |=> $stable(ctrl_b[1:0]))
    else $error("sub divider changed in subactive");
  chk_sleep_entry: assert property (@(posedge clk) disable iff (srst)
    active_now && sleep_exec && !standby_select && !direct_transfer_select
    |=> mode == MODE_SLEEP_HIGH || mode == MODE_SLEEP_MED)
    else $error("sleep entry missed");
  chk_standby_entry: assert property (@(posedge clk) disable iff (srst)
    active_now && sleep_exec && standby_select && !low_speed_select &&
    !timer_timebase_select |=> mode == MODE_STANDBY && !osc_run)
    else $error("standby entry missed");
  chk_settle_hold: assert property (@(posedge clk) disable iff (srst)
    mode == MODE_STANDBY && wake_irq && settle_code == 3'h0
    |=> clock_hold [*8] ##0 !service_start)
    else $error("settle wait cut short");
  chk_cpu_sub: assert property (@(posedge clk) disable iff (srst)
    cpu_clk_en && mode == MODE_SUBACT |-> watch_rise)
    else $error("sub clock enable off watch edge");
  chk_med_rate: assert property (@(posedge clk) disable iff (srst)
    mode == MODE_ACT_MED && cpu_clk_en && med_seen
    |-> gap_med == want_med - 8'h01)
    else $error("medium speed clock rate wrong");
  chk_sub_rate: assert property (@(posedge clk) disable iff (srst)
    mode == MODE_SUBACT && cpu_clk_en && sub_seen
    |-> gap_sub == want_sub - 8'h01)
    else $error("subactive clock rate wrong");
endmodule
`default_nettype wire

// file: test/pdm_cpu_model.sv
// CPU core model: register accesses and sleep instructions
`timescale 1ns/100ps
`default_nettype none
module pdm_cpu_model
  import pdm_pkg::*;
(
  // Clock and current mode
  input wire logic clk,
  input wire pdm_mode_t mode,
  // Register port and sleep event
  output logic addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata,
  output logic sleep_exec
);
  initial begin
    addr = 1'b0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    sleep_exec = 1'b0;
  end
  task write_reg(input logic a, input logic [7:0] d);
    // divider only written in high speed or subactive
    if (a == ADDR_CTRL_A && mode != MODE_ACT_HIGH && mode != MODE_SUBACT)
      return;
    // noise select set only because this clock is far above 10 MHz
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task read_reg(input logic a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task sleep_op;
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #1;
  endtask
endmodule
`default_nettype wire

// file: test/power_down_mode_control_tb_top.sv
// Testbench for the power-down mode control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module power_down_mode_control_tb_top
  import pdm_pkg::*;
;
  typedef struct {
    logic [7:0] a; logic [7:0] b; logic t; logic [7:0] ra; logic [7:0] rb;
    pdm_mode_t m; logic osc;
  } pdm_row_t;
  logic clk, srst, addr, wr, rd, sleep_exec, wake_irq, tmb, watch_clk;
  logic [7:0] wdata, rdata, rv;
  pdm_mode_t mode;
  logic osc_run, clock_hold, service_start, cpu_clk_en, cpu_on_sub;
  logic noise_sample_en;
  int err_count, samples_checked, wcnt, n, i;
  pdm_row_t rows [7];
  // ****************************************
  // Design, CPU model and clocks
  // ****************************************
  pdm_power_mode i_dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sleep_exec(sleep_exec),
    .wake_irq(wake_irq), .timer_timebase_select(tmb), .watch_clk(watch_clk),
    .mode(mode), .osc_run(osc_run), .clock_hold(clock_hold),
    .service_start(service_start), .cpu_clk_en(cpu_clk_en),
    .cpu_on_sub(cpu_on_sub), .noise_sample_en(noise_sample_en));
  pdm_cpu_model i_cpu (.clk(clk), .mode(mode), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sleep_exec(sleep_exec));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watch clock of ten system cycles keeps subactive periods exact
  always @(posedge clk) begin
    wcnt <= (wcnt == 4) ? 0 : wcnt + 1;
    if (wcnt == 4) watch_clk <= ~watch_clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task do_reset;
    @(posedge clk);
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
  endtask
  task setup(input logic [7:0] a, input logic [7:0] b, input logic t);
    do_reset;
    i_cpu.write_reg(1'b0, a);
    i_cpu.write_reg(1'b1, b);
    tmb <= t;
  endtask
  task run_row(input pdm_row_t r);
    setup(r.a, r.b, r.t);
    i_cpu.read_reg(1'b0, rv);
    `CHK("ctrl_a", r.ra, rv)
    i_cpu.read_reg(1'b1, rv);
    `CHK("ctrl_b", r.rb, rv)
    i_cpu.sleep_op;
    `CHK("mode", r.m, mode)
    `CHK("osc_run", r.osc, osc_run)
    `CHK("cpu_on_sub", r.m == MODE_SUBACT, cpu_on_sub)
  endtask
  // Second gap between pulses, so a reload at wrap has settled
  task period(input logic sel, output int g);
    for (int k = 0; k < 3; k++) begin
      g = 0;
      do begin
        @(posedge clk);
        #1;
        g++;
      end while ((sel ? noise_sample_en : cpu_clk_en) !== 1'b1 && g < 4000);
    end
  endtask
  task wake;
    @(posedge clk);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    #1;
  endtask
  task hold_len(output int c);
    c = 0;
    while (clock_hold === 1'b1 && c < 20000) begin
      c++;
      @(posedge clk);
      #1;
    end
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    srst = 1'b1; wake_irq = 1'b0; tmb = 1'b0; watch_clk = 1'b0; wcnt = 0;
    err_count = 0; samples_checked = 0;
    rows = '{
      '{8'h00, 8'hE0, 1'b0, 8'h04, 8'hE0, MODE_SLEEP_HIGH, 1'b1},
      '{8'h00, 8'h04, 1'b0, 8'h04, 8'hE4, MODE_SLEEP_MED, 1'b1},
      '{8'h80, 8'h00, 1'b0, 8'h84, 8'hE0, MODE_STANDBY, 1'b0},
      '{8'h80, 8'hE0, 1'b1, 8'h84, 8'hE0, MODE_WATCH, 1'b0},
      '{8'h03, 8'hEC, 1'b0, 8'h07, 8'hEC, MODE_ACT_MED, 1'b1},
      '{8'h88, 8'h08, 1'b1, 8'h8C, 8'hE8, MODE_SUBACT, 1'b0},
      '{8'hFF, 8'h1F, 1'b1, 8'hFF, 8'hFF, MODE_SUBACT, 1'b0}};
    do_reset;
    i_cpu.read_reg(1'b0, rv);
    `CHK("reset ctrl_a", 8'h07, rv)
    i_cpu.read_reg(1'b1, rv);
    `CHK("reset ctrl_b", 8'hE0, rv)
    `CHK("reset mode", MODE_ACT_HIGH, mode)
    for (i = 0; i < 7; i++) run_row(rows[i]);
    run_row(rows[1]);
    wake;
    `CHK("sleep wake mode", MODE_ACT_MED, mode)
    `CHK("sleep wake service", 1'b1, service_start)
    run_row(rows[2]);
    wake;
    hold_len(n);
    `CHK("settle cycles", 8192, n)
    `CHK("settle mode", MODE_ACT_HIGH, mode)
    `CHK("settle service", 1'b1, service_start)
    // short settle code, keeps the run brief
    setup(8'h98, 8'hE0, 1'b1);
    i_cpu.sleep_op;
    `CHK("watch entry", MODE_WATCH, mode)
    wake;
    hold_len(n);
    `CHK("watch settle cycles", 16384, n)
    `CHK("watch wake mode", MODE_SUBACT, mode)
    `CHK("watch wake clock", 1'b1, cpu_on_sub)
    run_row(rows[5]);
    i_cpu.write_reg(1'b1, 8'hEB);
    i_cpu.read_reg(1'b1, rv);
    `CHK("sub divider kept", 8'hE8, rv)
    i_cpu.write_reg(1'b0, 8'h80);
    i_cpu.sleep_op;
    `CHK("sub to high", MODE_ACT_HIGH, mode)
    run_row(rows[4]);
    i_cpu.write_reg(1'b1, 8'hE8);
    i_cpu.sleep_op;
    `CHK("med to high", MODE_ACT_HIGH, mode)
    for (i = 0; i < 4; i++) begin
      setup(i[7:0], 8'hEC, 1'b0);
      i_cpu.sleep_op;
      period(1'b0, n);
      `CHK("medium period", 16 << i, n)
    end
    for (i = 0; i < 2; i++) begin
      setup(8'h07, 8'hE0 | (i[0] ? 8'h10 : 8'h00), 1'b0);
      period(1'b1, n);
      `CHK("noise period", i[0] ? 4 : 16, n)
    end
    for (i = 0; i < 3; i++) begin
      setup(8'h88, 8'hE8 | i[7:0], 1'b1);
      i_cpu.sleep_op;
      period(1'b0, n);
      `CHK("sub period", 10 * (i[1] ? 2 : (i[0] ? 4 : 8)), n)
    end
    summarize;
  end
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    summarize;
  end
endmodule
`default_nettype wire
